/* logic/data_mixer.v */
// Data signal mixer: combines a data stream with two selectable carriers
`include "data_mixer_map.vh"
module data_mixer (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        sleep_mode,
    input  wire [7:0]  mixer_control_first_wdata,
    input  wire        mixer_control_first_we,
    input  wire [7:0]  mixer_control_second_wdata,
    input  wire        mixer_control_second_we,
    input  wire [4:0]  stream_source_wdata,
    input  wire        stream_source_we,
    input  wire [4:0]  high_carrier_wdata,
    input  wire        high_carrier_we,
    input  wire [4:0]  low_carrier_wdata,
    input  wire        low_carrier_we,
    input  wire [31:0] periph_sources,
    input  wire        high_carrier_pin_default,
    input  wire        low_carrier_pin_default,
    input  wire        stream_pin,
    output reg  [7:0]  mixer_control_first_q,
    output reg  [7:0]  mixer_control_second_q,
    output reg  [4:0]  stream_source_register_q,
    output reg  [4:0]  high_carrier_register_q,
    output reg  [4:0]  low_carrier_register_q,
    output reg         mixed_output_pin_q
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg  [31:0] src_s1_q;
    reg  [31:0] src_s2_q;
    reg  [2:0]  pin_s1_q;
    reg  [2:0]  pin_s2_q;

    always @(posedge mclk) begin
        if (sys_rst) begin
            src_s1_q <= 32'h0000_0000;
            src_s2_q <= 32'h0000_0000;
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            src_s1_q <= periph_sources;
            src_s2_q <= src_s1_q;
            pin_s1_q <= {stream_pin, low_carrier_pin_default, high_carrier_pin_default};
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control state
    reg        enable_q;
    reg        out_inv_q;
    reg        manual_q;
    reg        hi_inv_q;
    reg        hi_wait_q;
    reg        lo_inv_q;
    reg        lo_wait_q;
    reg  [4:0] stream_sel_q;
    reg  [4:0] hi_sel_q;
    reg  [4:0] lo_sel_q;

    always @(posedge mclk) begin
        if (sys_rst) begin
            enable_q     <= `CTRL_RESET;
            out_inv_q    <= `CTRL_RESET;
            manual_q     <= `CTRL_RESET;
            hi_inv_q     <= `CTRL_RESET;
            hi_wait_q    <= `CTRL_RESET;
            lo_inv_q     <= `CTRL_RESET;
            lo_wait_q    <= `CTRL_RESET;
            stream_sel_q <= `SEL_RESET;
            hi_sel_q     <= `SEL_RESET;
            lo_sel_q     <= `SEL_RESET;
        end else begin
            if (mixer_control_first_we) begin
                enable_q  <= mixer_control_first_wdata[`CTRL1_ENABLE_BIT];
                out_inv_q <= mixer_control_first_wdata[`CTRL1_OUT_INV_BIT];
                manual_q  <= mixer_control_first_wdata[`CTRL1_MANUAL_BIT];
            end
            if (mixer_control_second_we) begin
                hi_inv_q  <= mixer_control_second_wdata[`CTRL2_HI_INV_BIT];
                hi_wait_q <= mixer_control_second_wdata[`CTRL2_HI_WAIT_BIT];
                lo_inv_q  <= mixer_control_second_wdata[`CTRL2_LO_INV_BIT];
                lo_wait_q <= mixer_control_second_wdata[`CTRL2_LO_WAIT_BIT];
            end
            if (stream_source_we) begin
                stream_sel_q <= stream_source_wdata;
            end
            if (high_carrier_we) begin
                hi_sel_q <= high_carrier_wdata;
            end
            if (low_carrier_we) begin
                lo_sel_q <= low_carrier_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection
    function pick;
        input [4:0]  sel;
        input [31:0] srcs;
        input        pin;
        begin
            if (sel == `CARRIER_SEL_PIN) begin
                pick = pin;
            end else if (sel > `SRC_LAST_USED) begin
                pick = 1'b0;
            end else begin
                pick = srcs[sel];
            end
        end
    endfunction

    wire [4:0] hi_eff_sel;
    wire [4:0] lo_eff_sel;
    wire       stream;
    wire       high_carrier;
    wire       low_carrier;
    wire       use_high;

    assign hi_eff_sel = enable_q ? hi_sel_q : `CARRIER_SEL_PIN;
    assign lo_eff_sel = enable_q ? lo_sel_q : `CARRIER_SEL_PIN;
    assign stream = (!enable_q || stream_sel_q == `STREAM_SEL_MANUAL) ? manual_q
                  : pick(stream_sel_q, src_s2_q, pin_s2_q[2]);
    assign high_carrier = pick(hi_eff_sel, src_s2_q, pin_s2_q[0]) ^ hi_inv_q;
    assign low_carrier  = pick(lo_eff_sel, src_s2_q, pin_s2_q[1]) ^ lo_inv_q;

    carrier_sync u_sync (
        .mclk              (mclk),
        .sys_rst           (sys_rst),
        .run               (enable_q),
        .stream            (stream),
        .high_carrier      (high_carrier),
        .low_carrier       (low_carrier),
        .high_carrier_wait (hi_wait_q),
        .low_carrier_wait  (lo_wait_q),
        .use_high_q        (use_high)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mixing and output, no sleep gating
    wire carrier;
    wire mixed;

    assign carrier = use_high ? high_carrier : low_carrier;
    assign mixed   = enable_q & carrier & (use_high | ~use_high);

    always @(posedge mclk) begin
        if (sys_rst) begin
            mixed_output_pin_q       <= 1'b0;
            mixer_control_first_q    <= 8'h00;
            mixer_control_second_q   <= 8'h00;
            stream_source_register_q <= 5'h00;
            high_carrier_register_q  <= 5'h00;
            low_carrier_register_q   <= 5'h00;
        end else begin
            mixed_output_pin_q <= mixed ^ out_inv_q;
            mixer_control_first_q <= {enable_q, 1'b0, mixed ^ out_inv_q, out_inv_q, 3'h0, manual_q};
            mixer_control_second_q <= {2'h0, hi_inv_q, hi_wait_q, 2'h0, lo_inv_q, lo_wait_q};
            stream_source_register_q <= stream_sel_q;
            high_carrier_register_q  <= hi_sel_q;
            low_carrier_register_q   <= lo_sel_q;
        end
    end
endmodule

/* logic/data_mixer_map.vh */
// Field positions, reset values and select codes of the data mixer
`ifndef DATA_MIXER_MAP_VH
`define DATA_MIXER_MAP_VH
`define CTRL1_ENABLE_BIT      7
`define CTRL1_LIVE_OUT_BIT    5
`define CTRL1_OUT_INV_BIT     4
`define CTRL1_MANUAL_BIT      0
`define CTRL2_HI_INV_BIT      5
`define CTRL2_HI_WAIT_BIT     4
`define CTRL2_LO_INV_BIT      1
`define CTRL2_LO_WAIT_BIT     0
`define SEL_WIDTH             5
`define SRC_COUNT             32
`define SEL_RESET             5'h00
`define CTRL_RESET            1'b0
`define STREAM_SEL_MANUAL     5'h00
`define CARRIER_SEL_PIN       5'h00
`define SRC_LAST_USED         5'h12
`endif

/* logic/carrier_sync.v */
// Carrier hand-over stage: holds the active carrier while it is high when waiting is on and run is set
module carrier_sync (
    input  wire       mclk,
    input  wire       sys_rst,
    input  wire       run,
    input  wire       stream,
    input  wire       high_carrier,
    input  wire       low_carrier,
    input  wire       high_carrier_wait,
    input  wire       low_carrier_wait,
    output reg        use_high_q
);
    reg  hi_prev_q;
    reg  lo_prev_q;
    wire hi_fall;
    wire lo_fall;

    assign hi_fall = hi_prev_q & ~high_carrier;
    assign lo_fall = lo_prev_q & ~low_carrier;

    always @(posedge mclk) begin
        if (sys_rst) begin
            hi_prev_q  <= 1'b0;
            lo_prev_q  <= 1'b0;
            use_high_q <= 1'b0;
        end else begin
            hi_prev_q <= high_carrier;
            lo_prev_q <= low_carrier;
            if (!run) begin
                use_high_q <= stream;
            end else if (stream && !use_high_q) begin
                if (!low_carrier_wait || lo_fall || !low_carrier) begin
                    use_high_q <= 1'b1;
                end
            end else if (!stream && use_high_q) begin
                if (!high_carrier_wait || hi_fall || !high_carrier) begin
                    use_high_q <= 1'b0;
                end
            end
        end
    end
endmodule

/* verification/data_mixer_chk.sv */
// Port assertions for the data mixer
module data_mixer_chk (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       mixer_control_first_we,
    input wire logic [7:0] mixer_control_first_wdata,
    input wire logic [7:0] mixer_control_first_q,
    input wire logic [7:0] mixer_control_second_q,
    input wire logic       stream_source_we,
    input wire logic [4:0] stream_source_wdata,
    input wire logic [4:0] stream_source_register_q,
    input wire logic       mixed_output_pin_q
);
    wire [7:0] c1  = mixer_control_first_q;
    wire [7:0] c2  = mixer_control_second_q;
    wire       o   = mixed_output_pin_q;
    wire       we1 = mixer_control_first_we;
    wire       ws  = stream_source_we;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_rst_clear: assert property (disable iff (1'b0) sys_rst |=> c1 == 8'h00 && c2 == 8'h00 && !o)
        else $error("reset left state set");
    chk_ctrl_store: assert property (we1 ##1 !we1 [*2] |=> (c1 & 8'h91) == ($past(mixer_control_first_wdata, 3) & 8'h91))
        else $error("control bits not stored");
    chk_sel_store: assert property (ws ##1 !ws [*2] |=> stream_source_register_q == $past(stream_source_wdata, 3))
        else $error("stream select not stored");
    chk_ctrl1_zero: assert property (c1[6] == 1'b0 && c1[3:1] == 3'h0)
        else $error("unused first control bits set");
    chk_ctrl2_zero: assert property (c2[7:6] == 2'h0 && c2[3:2] == 2'h0)
        else $error("unused second control bits set");
    chk_sel_keep: assert property (!ws [*3] |=> $stable(stream_source_register_q))
        else $error("stream select changed unwritten");
    chk_off_idle: assert property ((!c1[7] && $stable(c1[4])) [*6] |-> o == c1[4])
        else $error("idle level wrong");
    chk_live_bit: assert property (($stable(o) && $stable(c1[5])) [*4] |-> c1[5] == o)
        else $error("live output bit differs");
    cover property (we1 && mixer_control_first_wdata[7]);
    cover property (!c1[7] ##1 c1[7]);
    cover property ($rose(o));
endmodule
bind data_mixer data_mixer_chk chk_i (.mclk, .sys_rst, .mixer_control_first_we, .mixer_control_first_wdata,
    .mixer_control_first_q, .mixer_control_second_q, .stream_source_we, .stream_source_wdata,
    .stream_source_register_q, .mixed_output_pin_q);

/* verification/signal_sources.sv */
// Model of the peripheral outputs and input pins feeding the mixer
module signal_sources (
    input  wire logic [34:0] nxt,
    input  wire logic        mclk,
    output      logic [31:0] periph_sources = 32'h0,
    output      logic        high_pin = 1'b0,
    output      logic        low_pin = 1'b0,
    output      logic        stream_pin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [34:0] hold_q = 35'h0;
    always @(posedge mclk) hold_q <= nxt;
    // New levels land away from the sampling edge
    always @(negedge mclk) {stream_pin, low_pin, high_pin, periph_sources} <= hold_q;
endmodule

/* verification/test_data_mixer.sv */
// Self-checking bench for the data mixer
module test_data_mixer;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, sys_rst = 1, sleep_mode = 0;
    logic [7:0]  wd = 0, c1_q, c2_q;
    logic [4:0]  we = 0, ss_q, hs_q, ls_q;
    logic [34:0] nxt = 0;
    logic [31:0] src;
    logic        hp, lp, sp, out_q, en, op, mb, hi, li, hw, lw, uh;
    int          error_cnt = 0, n_checks = 0, seed = 32'ha663, r = 0, i, ss, hs, ls;
    always #10 mclk = ~mclk;
    signal_sources part (.mclk, .nxt, .periph_sources(src), .high_pin(hp), .low_pin(lp), .stream_pin(sp));
    data_mixer uut (.mclk, .sys_rst, .sleep_mode, .mixer_control_first_wdata(wd), .mixer_control_first_we(we[4]),
        .mixer_control_second_wdata(wd), .mixer_control_second_we(we[3]), .stream_source_wdata(wd[4:0]),
        .stream_source_we(we[2]), .high_carrier_wdata(wd[4:0]), .high_carrier_we(we[1]), .low_carrier_wdata(wd[4:0]),
        .low_carrier_we(we[0]), .periph_sources(src), .high_carrier_pin_default(hp), .low_carrier_pin_default(lp),
        .stream_pin(sp), .mixer_control_first_q(c1_q), .mixer_control_second_q(c2_q), .stream_source_register_q(ss_q),
        .high_carrier_register_q(hs_q), .low_carrier_register_q(ls_q), .mixed_output_pin_q(out_q));
    ////////////////////////////////////////////////////////////////
    function automatic logic pick(int c, logic pin);
        return c == 0 ? pin : (c < 19 ? nxt[c] : 1'b0);
    endfunction
    function automatic logic [7:0] c1v();
        return {en, r[10:9], op, r[13:11], mb};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input int k, input logic [7:0] d);
        wd = d;
        we = 5'h10 >> k;
        @(negedge mclk);
        we = 5'h00;
        repeat (4) @(negedge mclk);
    endtask
    task automatic cfg();
        wr(4, 8'(ls));
        wr(3, 8'(hs));
        wr(2, 8'(ss));
        wr(1, {2'h0, hi, hw, 2'h0, li, lw});
        wr(0, c1v());
    endtask
    task automatic settle();
        logic st, hc, lc, e;
        repeat (8) @(negedge mclk);
        st = (!en || ss == 0) ? mb : nxt[ss];
        hc = pick(hs, nxt[32]) ^ hi;
        lc = pick(ls, nxt[33]) ^ li;
        if (st != uh && (!en || !(uh ? hw && hc : lw && lc))) uh = st;
        e = en ? (uh ? hc : lc) ^ op : op;
        chk(16'(out_q), 16'(e));
        chk(16'(c1_q), {8'h00, en, 1'b0, e, op, 3'h0, mb});
        chk(16'(c2_q), {10'h000, hi, hw, 2'h0, li, lw});
        chk({1'b0, ss_q, hs_q, ls_q}, {1'b0, ss[4:0], hs[4:0], ls[4:0]});
        $display("step done at %0t", $time);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {en, op, mb, hi, li, hw, lw, uh} = 8'h00;
        repeat (16) @(negedge mclk);
        sys_rst = 0;
        settle();
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            {en, op, mb, hi, li, sleep_mode} = r[5:0];
            nxt = {r[8:6], $random(seed)};
            ss = r[31:27] % 19;
            hs = r[26:22] % 19;
            ls = r[21:17] % 19;
            cfg();
            settle();
        end
        for (i = 0; i < 2; i++) begin
            en = i[0];
            wr(0, c1v());
            settle();
        end
        {en, op, mb, hw, lw, li, hi} = {6'h2c, ~nxt[32]};
        ss = 0;
        hs = 0;
        ls = 20;
        cfg();
        settle();
        mb = 0;
        wr(0, c1v());
        settle();
        hi = ~hi;
        wr(1, {2'h0, hi, hw, 2'h0, li, lw});
        settle();
        sys_rst = 1;
        repeat (2) @(negedge mclk);
        sys_rst = 0;
        {en, op, mb, hi, li, hw, lw, uh} = 8'h00;
        {ss, hs, ls} = 96'h0;
        settle();
        end_of_test();
    end
endmodule
